// *** core/asr_pkg.sv ***
// Constants and types for the serial readout host of a 16-bit converter.
// Assumes a 200 MHz system clock and a converter wired in slave serial mode.
//
// Function
// - Host drives clock source select high and supplies every shift edge.
// - Host may capture each bit on either shift clock edge; this host captures on the falling edge only.
// - When reading during conversion, all 16 bits finish before it ends; the host does not enforce this and only flags a late read.
// - Host holds the cascade input fixed in read-during-convert.
// - A fast discontinuous shift clock is advised during conversion.
// - A read after conversion may end after the next one starts.
// - A slow SPI-style host reads only after conversion completes.
// - Host starts reading when busy falls, or when busy rises in read-during-convert.
// - Host acts as master, polarity 0, phase 1, initiate field 00.
// - In read-after-convert the host limits its shift clock to 17 Mb/s.
// - Conversion starts may come from a periodic timer.

package asr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_DIV    = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_TIMER  = 5'h0C;
    localparam logic [4:0] REG_DATA0  = 5'h10;

    localparam int CTRL_START   = 0;
    localparam int CTRL_RDC     = 1;
    localparam int CTRL_TIMEREN = 2;
    localparam int CTRL_WORDS   = 3;
    localparam int CTRL_CASCADE = 5;

    localparam int STAT_BUSY   = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_DONE   = 2;
    localparam int STAT_LATE   = 3;

    localparam logic [5:0]  CTRL_RESET  = 6'h00;
    localparam logic [7:0]  DIV_RESET   = 8'h08;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_MHZ    = 200;
    localparam int WORD_BITS      = 16;
    localparam int MAX_WORDS      = 4;
    // Fastest serial rate allowed in read-after-convert, in Mb/s.
    localparam int SPI_MAX_MBPS   = 17;
    localparam int SPI_MIN_HALF   =
        (SYS_CLK_MHZ + 2 * SPI_MAX_MBPS - 1) / (2 * SPI_MAX_MBPS);
    // Least width of the start pulse, in ns.
    localparam int CNV_LOW_NS     = 15;
    localparam int CNV_LOW_CYC    = (CNV_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int MIN_HALF       = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CNV   = 3'b001,
        ST_WAIT  = 3'b010,
        ST_SETUP = 3'b011,
        ST_HIGH  = 3'b100,
        ST_LOW   = 3'b101,
        ST_END   = 3'b110
    } asr_state_t;

    typedef struct packed {
        logic convStartN;
        logic csN;
        logic rdN;
        logic sclk;
        logic cascadeLevel;
        logic clockSourceSelect;
        logic portKindSelect;
    } asr_pins_t;

endpackage

// *** core/asr_host.sv ***
// Host controller that starts conversions and shifts results out of the
// converter's slave serial port. Software reaches it over classic Wishbone.
// Assumes the converter pins arrive asynchronously and are synchronised here.

`timescale 1ns/1ps

module asr_host (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [4:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              busy,
    input  wire logic              serialResultOut,
    input  wire logic              lateReadErrorPulse,
    output asr_pkg::asr_pins_t     pins
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic       busyS;
    logic       dataS;
    logic       errS;
    logic       busyD;
    logic       errD;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
        end else begin
            syncA <= {lateReadErrorPulse, serialResultOut, busy};
            syncB <= syncA;
        end
    end

    assign busyS = syncB[0];
    assign dataS = syncB[1];
    assign errS  = syncB[2];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busyD <= 1'b0;
            errD  <= 1'b0;
        end else begin
            busyD <= busyS;
            errD  <= errS;
        end
    end

    logic busyFall;
    logic busyRise;
    logic errRise;

    assign busyFall = busyD & ~busyS;
    assign busyRise = ~busyD & busyS;
    assign errRise  = ~errD & errS;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [5:0]  ctrl;
    logic [7:0]  div;
    logic [31:0] timerPeriod;
    logic [31:0] timerCnt;
    logic        doneFlag;
    logic        lateFlag;
    logic [15:0] words [asr_pkg::MAX_WORDS];

    logic wbReq;
    logic wbWr;
    logic startReq;
    logic timerHit;
    logic rdcMode;
    logic [1:0] wordsM1;

    assign wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wbWr    = wbReq & wb_we_i & wb_sel_i[0];
    assign rdcMode = ctrl[asr_pkg::CTRL_RDC];
    // Chaining is meaningless while reading during a conversion.
    assign wordsM1 = rdcMode ? 2'h0 :
                     ctrl[asr_pkg::CTRL_WORDS +: 2];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbReq;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl        <= asr_pkg::CTRL_RESET;
            div         <= asr_pkg::DIV_RESET;
            timerPeriod <= asr_pkg::TIMER_RESET;
        end else if (wbWr) begin
            unique case (wb_adr_i)
                asr_pkg::REG_CTRL: begin
                    ctrl <= wb_dat_i[5:0];
                end
                asr_pkg::REG_DIV: begin
                    div <= wb_dat_i[7:0];
                end
                asr_pkg::REG_TIMER: begin
                    timerPeriod <= wb_dat_i;
                end
                default: begin
                end
            endcase
        end else begin
            ctrl[asr_pkg::CTRL_START] <= 1'b0;
        end
    end

    assign startReq = ctrl[asr_pkg::CTRL_START] | timerHit;

    // Periodic start source; a tick while the sequencer is not idle is simply dropped.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timerCnt <= 32'h0000_0000;
        end else if (!ctrl[asr_pkg::CTRL_TIMEREN] || timerHit) begin
            timerCnt <= 32'h0000_0000;
        end else begin
            timerCnt <= timerCnt + 32'h0000_0001;
        end
    end

    assign timerHit = ctrl[asr_pkg::CTRL_TIMEREN] &&
                      timerPeriod != 32'h0000_0000 &&
                      timerCnt >= timerPeriod;

    // ************************************************************
    // Readout sequencer
    // ************************************************************
    asr_pkg::asr_state_t state;
    logic [7:0]  phaseCnt;
    logic [5:0]  bitCnt;
    logic [15:0] shiftReg;
    logic        rdcRun;
    logic [7:0]  halfCycles;
    logic        finishWord;
    logic        lastBit;
    logic        lateSet;
    logic        wordDone;

    // Read-after-convert must keep under the SPI rate; read-during-convert
    // only has the divider floor so it can run as fast as the sampling allows.
    always_comb begin
        halfCycles = div;
        if (!rdcMode && div < 8'(asr_pkg::SPI_MIN_HALF)) begin
            halfCycles = 8'(asr_pkg::SPI_MIN_HALF);
        end
        if (halfCycles < 8'(asr_pkg::MIN_HALF)) begin
            halfCycles = 8'(asr_pkg::MIN_HALF);
        end
    end

    assign lastBit    = bitCnt == {wordsM1, 4'hF};
    assign finishWord = state == asr_pkg::ST_LOW && phaseCnt == 8'h01;
    assign wordDone   = state == asr_pkg::ST_HIGH && phaseCnt == 8'h01 &&
                        bitCnt[3:0] == 4'hF;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= asr_pkg::ST_IDLE;
            phaseCnt <= 8'h00;
            bitCnt   <= 6'h00;
            rdcRun   <= 1'b0;
        end else begin
            unique case (state)
                asr_pkg::ST_IDLE: begin
                    bitCnt <= 6'h00;
                    if (startReq) begin
                        state    <= asr_pkg::ST_CNV;
                        rdcRun   <= rdcMode;
                        phaseCnt <= 8'(asr_pkg::CNV_LOW_CYC);
                    end
                end
                asr_pkg::ST_CNV: begin
                    if (phaseCnt == 8'h01) begin
                        state <= asr_pkg::ST_WAIT;
                    end else begin
                        phaseCnt <= phaseCnt - 8'h01;
                    end
                end
                asr_pkg::ST_WAIT: begin
                    // During a conversion the previous word is read as soon as
                    // busy is seen; otherwise the falling busy opens the read.
                    if ((rdcRun && busyRise) ||
                        (!rdcRun && busyFall)) begin
                        state    <= asr_pkg::ST_SETUP;
                        phaseCnt <= halfCycles;
                    end
                end
                asr_pkg::ST_SETUP: begin
                    if (phaseCnt == 8'h01) begin
                        state    <= asr_pkg::ST_HIGH;
                        phaseCnt <= halfCycles;
                    end else begin
                        phaseCnt <= phaseCnt - 8'h01;
                    end
                end
                asr_pkg::ST_HIGH: begin
                    if (phaseCnt == 8'h01) begin
                        state    <= asr_pkg::ST_LOW;
                        phaseCnt <= halfCycles;
                    end else begin
                        phaseCnt <= phaseCnt - 8'h01;
                    end
                end
                asr_pkg::ST_LOW: begin
                    if (phaseCnt != 8'h01) begin
                        phaseCnt <= phaseCnt - 8'h01;
                    end else if (lastBit) begin
                        state    <= asr_pkg::ST_END;
                        phaseCnt <= halfCycles;
                    end else begin
                        state    <= asr_pkg::ST_HIGH;
                        phaseCnt <= halfCycles;
                        bitCnt   <= bitCnt + 6'h01;
                    end
                end
                asr_pkg::ST_END: begin
                    if (phaseCnt == 8'h01) begin
                        state <= asr_pkg::ST_IDLE;
                    end else begin
                        phaseCnt <= phaseCnt - 8'h01;
                    end
                end
                default: begin
                    state <= asr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Capture at the end of the high half, just as the falling edge is made:
    // the bit has been stable for a whole half period by then, well past the
    // synchroniser delay.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shiftReg <= 16'h0000;
        end else if (state == asr_pkg::ST_HIGH && phaseCnt == 8'h01) begin
            shiftReg <= {shiftReg[14:0], dataS};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < asr_pkg::MAX_WORDS; gi++) begin : gWords
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    words[gi] <= 16'h0000;
                end else if (wordDone && bitCnt[5:4] == 2'(gi)) begin
                    words[gi] <= {shiftReg[14:0], dataS};
                end
            end
        end
    endgenerate

    // A read still shifting when the running conversion ends is late, either
    // as the converter reports it or as seen here from busy.
    assign lateSet = errRise ||
                     (rdcRun && busyFall &&
                      (state == asr_pkg::ST_SETUP ||
                       state == asr_pkg::ST_HIGH ||
                       state == asr_pkg::ST_LOW));

    // Sticky flags; an event in the clearing cycle keeps the flag set.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            doneFlag <= 1'b0;
            lateFlag <= 1'b0;
        end else begin
            if (finishWord && lastBit) begin
                doneFlag <= 1'b1;
            end else if (wbWr && wb_adr_i == asr_pkg::REG_STATUS &&
                         wb_dat_i[asr_pkg::STAT_DONE]) begin
                doneFlag <= 1'b0;
            end
            if (lateSet) begin
                lateFlag <= 1'b1;
            end else if (wbWr && wb_adr_i == asr_pkg::REG_STATUS &&
                         wb_dat_i[asr_pkg::STAT_LATE]) begin
                lateFlag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Pins and read data
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pins <= '{convStartN: 1'b1, csN: 1'b1, rdN: 1'b1, sclk: 1'b0,
                      cascadeLevel: 1'b0, clockSourceSelect: 1'b1,
                      portKindSelect: 1'b1};
        end else begin
            pins.convStartN <= state != asr_pkg::ST_CNV;
            // Select and read fall together; the MSB is already on the line
            // before the first edge, so the setup half needs no clock.
            pins.csN  <= !(state == asr_pkg::ST_SETUP ||
                           state == asr_pkg::ST_HIGH ||
                           state == asr_pkg::ST_LOW);
            pins.rdN  <= !(state == asr_pkg::ST_SETUP ||
                           state == asr_pkg::ST_HIGH ||
                           state == asr_pkg::ST_LOW);
            // Polarity 0, phase 1: idle low, launch on rise, capture on fall.
            pins.sclk <= state == asr_pkg::ST_HIGH;
            // Static level only; it never toggles under software control
            // while a read is running.
            if (state == asr_pkg::ST_IDLE) begin
                pins.cascadeLevel <= ctrl[asr_pkg::CTRL_CASCADE];
            end
            pins.clockSourceSelect <= 1'b1;
            pins.portKindSelect    <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
                asr_pkg::REG_CTRL: begin
                    wb_dat_o <= {26'h0000000, ctrl};
                end
                asr_pkg::REG_DIV: begin
                    wb_dat_o <= {24'h000000, div};
                end
                asr_pkg::REG_STATUS: begin
                    wb_dat_o <= {28'h0000000, lateFlag, doneFlag,
                                 state != asr_pkg::ST_IDLE, busyS};
                end
                asr_pkg::REG_TIMER: begin
                    wb_dat_o <= timerPeriod;
                end
                5'h10, 5'h14, 5'h18, 5'h1C: begin
                    wb_dat_o <= {16'h0000, words[wb_adr_i[3:2]]};
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// *** tb/asr_host_assertions.sv ***
// Port-level checks for the converter readout host.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps

module asr_host_assertions (
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [4:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               busy,
    input wire logic               serialResultOut,
    input wire logic               lateReadErrorPulse,
    input wire asr_pkg::asr_pins_t pins
);
    logic [7:0] nRise;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Counts shift clock rises within one select window.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            nRise <= 8'h00;
        end else if (pins.csN) begin
            nRise <= 8'h00;
        end else if ($rose(pins.sclk)) begin
            nRise <= nRise + 8'h01;
        end
    end

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus ack lasted more than one cycle.");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus request not answered in one cycle.");
    fixed_pins_a: assert property (
        pins.clockSourceSelect && pins.portKindSelect)
        else $error("Mode pins left their fixed levels.");
    sclk_gate_a: assert property (pins.csN |-> !pins.sclk)
        else $error("Shift clock moved while deselected.");
    start_width_a: assert property (
        $fell(pins.convStartN) |-> !pins.convStartN [*3] ##1 pins.convStartN)
        else $error("Start pulse width wrong.");
    spi_rate_a: assert property (
        $rose(pins.sclk) && !pins.cascadeLevel |-> pins.sclk [*6])
        else $error("Shift clock too fast after conversion.");
    word_count_a: assert property (
        $rose(pins.csN) |-> nRise[3:0] == 4'h0 && nRise != 8'h00
            && (!pins.cascadeLevel || nRise == 8'h10))
        else $error("Frame is not a whole number of words.");
    read_after_a: assert property (
        $fell(pins.csN) && !pins.cascadeLevel |-> !busy)
        else $error("Read began before busy fell.");
    rdc_read_a: assert property (
        $fell(pins.csN) && pins.cascadeLevel |-> busy)
        else $error("Read during convert began outside conversion.");
    rd_cs_pair_a: assert property (pins.rdN == pins.csN)
        else $error("Read strobe and select moved apart.");
    cascade_fixed_a: assert property (
        !pins.csN |-> $stable(pins.cascadeLevel))
        else $error("Cascade level moved during a read.");
endmodule

bind asr_host asr_host_assertions i_chk (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy(busy), .serialResultOut(serialResultOut),
    .lateReadErrorPulse(lateReadErrorPulse), .pins(pins)
);

// *** tb/asr_adc_model.sv ***
// Behavioural converter with a slave serial port, for the host bench.
// Assumes the host drives every pin; conversion time comes from convNs.
`timescale 1ns/1ps

module asr_adc_model (
    input  wire asr_pkg::asr_pins_t pins,
    input  wire logic [15:0]        sample,
    input  wire logic [15:0]        convNs,
    output logic                    busy,
    output logic                    serialResultOut,
    output logic                    lateReadErrorPulse
);
    logic [15:0] word = 16'h0000;
    logic [15:0] sr = 16'h0000;
    logic        sdin = 1'b0;
    logic        rdcMode = 1'b0;
    logic        reading = 1'b0;
    int          bits = 0;
    wire         sel = !pins.csN && !pins.rdN;

    initial {busy, lateReadErrorPulse} = 2'b00;

    // ************************************************************
    // Conversion and serial shifter
    // ************************************************************
    // The shared mode pin is taken at the start of each conversion.
    always @(negedge pins.convStartN) begin
        rdcMode = pins.cascadeLevel;
        reading = 1'b0;
        busy = 1'b1;
        #(convNs);
        word = sample;
        busy = 1'b0;
        if (rdcMode && reading && bits < 16) begin
            lateReadErrorPulse = 1'b1;
            #30;
            lateReadErrorPulse = 1'b0;
        end
    end

    // The shifter is loaded only at select, so a read may outlive it.
    always @(posedge sel) begin
        sr = word;
        bits = 0;
        reading = 1'b1;
    end
    always @(posedge pins.sclk) begin
        if (!pins.csN) begin
            sdin = rdcMode ? 1'b0 : pins.cascadeLevel;
        end
    end
    always @(negedge pins.sclk) begin
        if (!pins.csN && pins.clockSourceSelect) begin
            sr = {sr[14:0], sdin};
            bits = bits + 1;
        end
    end
    // A released line shows the inverse of its last level.
    assign serialResultOut = sel ? sr[15] : ~sr[15];
endmodule

// *** tb/asr_host_test.sv ***
// Self-checking bench for the converter readout host.
// Assumes the behavioural converter model and the bound checker.
`timescale 1ns/1ps

module asr_host_test;
    logic               sys_clk;
    logic               rstn;
    logic               cyc;
    logic               stb;
    logic               we;
    logic [3:0]         sel;
    logic [4:0]         adr;
    logic [31:0]        datIn;
    logic [31:0]        datOut;
    logic [31:0]        rdata;
    logic               ack;
    logic               busy;
    logic               serialOut;
    logic               lateErr;
    logic [15:0]        sample;
    logic [15:0]        convNs;
    logic [15:0]        hist[$];
    asr_pkg::asr_pins_t pins;
    int                 nErrors = 0;
    int                 cmpCount = 0;

    asr_host i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datIn), .wb_dat_o(datOut), .wb_ack_o(ack), .busy(busy),
        .serialResultOut(serialOut), .lateReadErrorPulse(lateErr),
        .pins(pins));
    asr_adc_model i_adc (.pins(pins), .sample(sample), .convNs(convNs),
        .busy(busy), .serialResultOut(serialOut),
        .lateReadErrorPulse(lateErr));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic testDone();
        $display("Comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, got);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; returns one edge after release.
    task automatic wbXfer(input logic [4:0] a, input logic w,
                          input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        datIn <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1);
        rdata = datOut;
        // The registered ack answers one edge after the request is taken.
        check("bus latency", 32'h2, 32'(n));
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chkReg(input string what, input logic [4:0] a,
                          input logic [31:0] exp);
        wbXfer(a, 1'b0, 32'h0);
        check(what, exp, rdata);
    endtask

    // Runs one conversion and read; waits for done with busy low.
    task automatic convert(input logic [31:0] ctrl, input logic [7:0] div,
                           input logic [15:0] ns);
        logic [15:0] s;
        int n;
        s = 16'($urandom());
        n = 0;
        sample <= s;
        convNs <= ns;
        hist.push_back(s);
        wbXfer(5'h04, 1'b1, {24'h0, div});
        wbXfer(5'h00, 1'b1, ctrl);
        do begin
            wbXfer(5'h08, 1'b0, 32'h0);
            n++;
        end while (rdata[2:0] !== 3'b100 && n < 2000);
        check("done status", 32'h4, rdata & 32'h7);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #400000;
        nErrors++;
        testDone();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        {rstn, cyc, stb, we, sel, adr, datIn} = '0;
        sample = 16'h0000;
        convNs = 16'd600;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        void'($urandom(82));
        chkReg("ctrl reset", 5'h00, {26'h0, asr_pkg::CTRL_RESET});
        chkReg("div reset", 5'h04, {24'h0, asr_pkg::DIV_RESET});
        chkReg("timer reset", 5'h0C, asr_pkg::TIMER_RESET);
        chkReg("status reset", 5'h08, 32'h0);
        chkReg("unmapped", 5'h02, 32'h0);
        // Read after conversion, one to four chained words.
        for (int w = 0; w < 4; w++) begin
            convert((32'(w) << 3) | 32'h1, 8'(3 + $urandom % 10), 16'd600);
            for (int k = 0; k <= w; k++) begin
                chkReg("chained word", 5'h10 + 5'(4 * k),
                    k == 0 ? {16'h0, hist[$]} : 32'h0);
            end
            wbXfer(5'h08, 1'b1, 32'h4);
            chkReg("done cleared", 5'h08, 32'h0);
        end
        // Read during conversion gives the previous result.
        convert(32'h3B, 8'h03, 16'd2000);
        chkReg("previous result", 5'h10, {16'h0, hist[$-1]});
        chkReg("no late flag", 5'h08, 32'h4);
        wbXfer(5'h08, 1'b1, 32'hC);
        convert(32'h23, 8'h28, 16'd1000);
        chkReg("late flag", 5'h08, 32'hC);
        wbXfer(5'h08, 1'b1, 32'hC);
        chkReg("late cleared", 5'h08, 32'h0);
        // Timer-driven starts.
        wbXfer(5'h0C, 1'b1, 32'd2000);
        convert(32'h4, 8'h08, 16'd400);
        chkReg("timed result", 5'h10, {16'h0, hist[$]});
        wbXfer(5'h00, 1'b1, 32'h0);
        testDone();
    end
endmodule
